// *** dv/host_spi_model.sv ***
// Host model that drives the serial configuration port.
`timescale 1ns/1ns
module host_spi_model (
  input wire clk_i,
  input wire sdo_i,
  output reg cs_n_o = 1'b1,
  output reg sck_o = 1'b0,
  output reg sdi_o = 1'b0
);
  task half;
    begin
      repeat (4) @(posedge clk_i);
      #5;
    end
  endtask
  // Sends n bits of a word, read flag and address first, top bit first.
  task xfer(input [15:0] w, input integer n, output reg [7:0] rd);
    integer i;
    begin
      cs_n_o = 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        sdi_o = w[15 - i % 16];
        half;
        sck_o = 1'b1;
        if (i > 7 && i < 16) rd[15 - i] = sdo_i;
        half;
        sck_o = 1'b0;
      end
      half;
      cs_n_o = 1'b1;
      sdi_o = ~sdi_o;
      half;
    end
  endtask
  // Holds the three host-driven pins at fixed levels while they serve as straps.
  task set_pins(input [2:0] v);
    {cs_n_o, sck_o, sdi_o} = v;
  endtask
  // Waits out a power-state change before trusting data; ten clocks make one microsecond.
  task recover(input integer sample_cycles, input integer settle_us);
    begin
      repeat (sample_cycles) @(posedge clk_i);
      repeat (settle_us * 10) @(posedge clk_i);
      #5;
    end
  endtask
endmodule // host_spi_model

// *** dv/mode_config_port_properties.sv ***
// Checker for the mode configuration port decodes and data-out pin.
`timescale 1ns/1ns
module mode_config_port_properties (
  input wire clk_i,
  input wire rst_n_i,
  input wire interface_select_pin_i,
  input wire cs_n_pin_i,
  input wire sck_pin_i,
  input wire sdi_pin_i,
  input wire serial_out_pin_i,
  input wire serial_out_pin_oe_n_o,
  input wire chip_sleep_o,
  input wire [3:0] channel_nap_o,
  input wire two_lane_16bit_o,
  input wire low_drive_current_o,
  input wire termination_on_o,
  input wire [7:0] format_powerdown_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // A level held five clocks has passed the synchroniser and the output register.
  sequence s_par(x); (interface_select_pin_i && x)[*5]; endsequence
  sequence s_ser(x); (!interface_select_pin_i && x)[*5]; endsequence
  property p_lane; s_par(!cs_n_pin_i) |-> two_lane_16bit_o; endproperty
  a_lane: assert property (p_lane) else $error("bad lane decode");
  property p_drive; s_par(sck_pin_i) |-> low_drive_current_o; endproperty
  a_drive: assert property (p_drive) else $error("bad drive decode");
  property p_psleep; s_par(sdi_pin_i) |-> chip_sleep_o; endproperty
  a_psleep: assert property (p_psleep) else $error("no strap sleep");
  property p_term; s_par(serial_out_pin_i) |-> termination_on_o; endproperty
  a_term: assert property (p_term) else $error("bad termination");
  property p_pnap; s_par(1'b1) |-> channel_nap_o == 4'h0; endproperty
  a_pnap: assert property (p_pnap) else $error("nap in strap mode");
  property p_idle; s_ser(cs_n_pin_i) |-> serial_out_pin_oe_n_o; endproperty
  a_idle: assert property (p_idle) else $error("data-out driven idle");
  property p_sleep; s_ser(format_powerdown_o[4]) |-> chip_sleep_o && channel_nap_o == 4'h0;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep bit ignored");
  property p_nap; s_ser(!format_powerdown_o[4] && $stable(format_powerdown_o))
    |-> channel_nap_o == format_powerdown_o[3:0]; endproperty
  a_nap: assert property (p_nap) else $error("nap bits ignored");
endmodule // mode_config_port_properties

// *** dv/mode_config_port_tb.sv ***
// Self-checking bench for the mode configuration port.
`timescale 1ns/1ns
`include "mode_port_defs.vh"
module mode_config_port_tb;
  reg clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg interface_select_pin_i = 1'b0;
  reg ext = 1'b1;
  reg saw = 1'b0;
  wire cs_n_pin_i, sck_pin_i, sdi_pin_i, serial_out_pin_o, serial_out_pin_oe_n_o;
  wire chip_sleep_o, two_lane_16bit_o, one_lane_14bit_o, low_drive_current_o, termination_on_o;
  wire [3:0] channel_nap_o;
  wire [7:0] format_powerdown_o, output_mode_o, pattern_high_o, pattern_low_o;
  // The data-out wire takes the level of ext (high until the strap test drives it) unless the port pulls it low.
  wire serial_out_pin_i = serial_out_pin_oe_n_o ? ext : serial_out_pin_o;
  wire [7:0] straps = {two_lane_16bit_o, one_lane_14bit_o, low_drive_current_o, chip_sleep_o,
    termination_on_o, channel_nap_o[2:0]};
  integer err_count = 0;
  integer comparisons = 0;
  integer i;
  reg [7:0] r;
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) if (chip_sleep_o === 1'b1) saw <= 1'b1;
  mode_config_port dut (.clk_i, .rst_n_i, .interface_select_pin_i, .cs_n_pin_i, .sck_pin_i,
    .sdi_pin_i, .serial_out_pin_i, .serial_out_pin_o, .serial_out_pin_oe_n_o, .chip_sleep_o,
    .channel_nap_o, .two_lane_16bit_o, .one_lane_14bit_o, .low_drive_current_o,
    .termination_on_o, .format_powerdown_o, .output_mode_o, .pattern_high_o, .pattern_low_o);
  host_spi_model host (.clk_i, .sdo_i(serial_out_pin_i), .cs_n_o(cs_n_pin_i),
    .sck_o(sck_pin_i), .sdi_o(sdi_pin_i));
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("unexpected %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  task wr(input [6:0] a, input [7:0] d, input integer n);
    host.xfer({1'b0, a, d}, n, r);
  endtask
  task rdc(input [6:0] a, input [7:0] e);
    begin
      host.xfer({1'b1, a, 8'hFF}, 16, r);
      chk("readback", e, r);
    end
  endtask
  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    #5 rst_n_i = 1'b1;
    repeat (4) @(posedge clk_i);
    chk("format_reset", 8'h00, format_powerdown_o);
    wr(7'h00, 8'h80, 16);
    chk("sleep_pulse", 8'h01, {7'h0, saw});
    chk("sleep_end", 8'h00, {7'h0, chip_sleep_o});
    $display("test soft_reset done");
    for (i = 1; i < 5; i = i + 1) wr(i[6:0], 8'h21 + i[7:0], 16);
    for (i = 1; i < 5; i = i + 1) rdc(i[6:0], 8'h21 + i[7:0]);
    rdc(7'h00, 8'h00);
    wr(7'h05, 8'h5A, 16);
    rdc(7'h05, 8'h00);
    chk("nap", 8'h02, {4'h0, channel_nap_o});
    chk("pattern_low", 8'h25, pattern_low_o);
    chk("pattern_high", 8'h24, pattern_high_o);
    chk("output_mode", 8'h23, output_mode_o);
    $display("test registers done");
    wr(7'h01, 8'h10, 20);
    chk("sleep_set", 8'h10, {3'h0, chip_sleep_o, channel_nap_o});
    wr(7'h00, 8'h7F, 16);
    chk("low_bits", 8'h10, format_powerdown_o);
    wr(7'h02, 8'hF5, 16);
    chk("serial_decode", 8'h78, straps);
    wr(7'h00, 8'h80, 16);
    chk("cleared", 8'h00, output_mode_o);
    host.recover(0, `SLEEP_RECOVERY_US);
    wr(7'h01, 8'h01, 16);
    chk("after_reset", 8'h01, format_powerdown_o);
    chk("nap_one", 8'h01, {4'h0, channel_nap_o});
    wr(7'h01, 8'h00, 16);
    host.recover(`NAP_RECOVERY_SAMPLE_CYCLES, `NAP_SETTLE_US);
    chk("nap_exit", 8'h00, {4'h0, channel_nap_o});
    $display("test sleep_reset done");
    interface_select_pin_i = 1'b1;
    for (i = 0; i < 16; i = i + 1) begin
      host.set_pins(i[3:1]);
      ext = i[0];
      repeat (6) @(posedge clk_i);
      #5 chk("straps", {~i[3], i[3:0], 3'h0}, straps);
    end
    $display("test straps done");
    final_report;
  end
endmodule // mode_config_port_tb
bind mode_config_port mode_config_port_properties props (.clk_i, .rst_n_i,
  .interface_select_pin_i, .cs_n_pin_i, .sck_pin_i, .sdi_pin_i, .serial_out_pin_i,
  .serial_out_pin_oe_n_o, .chip_sleep_o, .channel_nap_o, .two_lane_16bit_o,
  .low_drive_current_o, .termination_on_o, .format_powerdown_o);

// *** rtl/mode_config_port.v ***
// Mode configuration port: parallel strap decode and serial register access.
`timescale 1ns/1ns
`include "mode_port_defs.vh"

// Every pin passes a two-stage synchroniser and the serial clock also an edge detector, so each serial
// clock level must stand for more than one system clock to be seen.
module mode_config_port (
  input wire clk_i,
  input wire rst_n_i,
  input wire interface_select_pin_i,
  input wire cs_n_pin_i,
  input wire sck_pin_i,
  input wire sdi_pin_i,
  input wire serial_out_pin_i,
  output wire serial_out_pin_o,
  output wire serial_out_pin_oe_n_o,
  output reg chip_sleep_o,
  output reg [3:0] channel_nap_o,
  output reg two_lane_16bit_o,
  output reg one_lane_14bit_o,
  output reg low_drive_current_o,
  output reg termination_on_o,
  output reg [7:0] format_powerdown_o,
  output reg [7:0] output_mode_o,
  output reg [7:0] pattern_high_o,
  output reg [7:0] pattern_low_o
);
  wire [4:0] pins_sync;
  reg sck_prev;
  reg reset_bit;
  reg [`BIT_COUNT_W-1:0] bit_count;
  reg [15:0] shift_in;
  reg [7:0] shift_out;
  reg reading;
  reg drive_low;
  reg [3:0] reset_sleep_count;
  reg [7:0] read_value;
  wire par_mode;
  wire cs_n;
  wire sck;
  wire sdi;
  wire sdo_in;
  wire sck_rise;
  wire sck_fall;
  wire active;
  wire [15:0] next_shift_in;
  wire [6:0] word_addr;
  wire take_bit;
  wire write_strobe;
  wire load_read;
  wire shift_read;
  wire sleep_all;
  wire [3:0] next_channel_nap;
  genvar ch;

  pin_sync #(.WIDTH(5)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({interface_select_pin_i, !cs_n_pin_i, sck_pin_i, sdi_pin_i, serial_out_pin_i}),
    .sync_o(pins_sync)
  );

  assign par_mode = pins_sync[4];
  // Chip-select is carried inverted so the cleared synchroniser reads as deselected.
  assign cs_n = !pins_sync[3];
  assign sck = pins_sync[2];
  assign sdi = pins_sync[1];
  assign sdo_in = pins_sync[0];
  assign active = !par_mode && !cs_n;
  assign sck_rise = active && sck && !sck_prev;
  assign sck_fall = active && !sck && sck_prev;
  assign next_shift_in = {shift_in[14:0], sdi};
  assign word_addr = next_shift_in[14:8];
  assign take_bit = sck_rise && (bit_count < `WORD_BITS);
  assign write_strobe = take_bit && (bit_count == 5'h0F) && !reading;
  assign load_read = take_bit && (bit_count == 5'h07) && reading;
  assign shift_read = sck_fall && reading && (bit_count >= 5'h08) && (bit_count <= 5'h0F);
  assign sleep_all = format_powerdown_o[`SLEEP_BIT];

  // Sleep overrides every channel nap bit.
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_nap
      assign next_channel_nap[ch] = format_powerdown_o[ch] && !sleep_all;
    end
  endgenerate

  // Open drain: the output value is always low and only the enable moves.
  assign serial_out_pin_o = 1'b0;
  assign serial_out_pin_oe_n_o = !(drive_low && active && reading);

  always @* begin
    case (next_shift_in[6:0])
      `ADDR_FORMAT_POWERDOWN: read_value = format_powerdown_o;
      `ADDR_OUTPUT_MODE: read_value = output_mode_o;
      `ADDR_PATTERN_HIGH: read_value = pattern_high_o;
      `ADDR_PATTERN_LOW: read_value = pattern_low_o;
      default: read_value = 8'h00;
    endcase
  end

  // Frame state: bit counter, input shift register and the read flag.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sck_prev <= 1'b0;
      bit_count <= {`BIT_COUNT_W{1'b0}};
      shift_in <= 16'h0000;
      reading <= 1'b0;
    end else begin
      sck_prev <= sck;
      if (!active) begin
        bit_count <= {`BIT_COUNT_W{1'b0}};
        reading <= 1'b0;
      end else if (take_bit) begin
        shift_in <= next_shift_in;
        bit_count <= bit_count + 5'h01;
        if (bit_count == 5'h00) begin
          reading <= sdi;
        end
      end
    end
  end

  // Read data changes on falling edges so the host samples it on rising ones.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      shift_out <= 8'h00;
      drive_low <= 1'b0;
    end else if (!active) begin
      drive_low <= 1'b0;
    end else if (load_read) begin
      shift_out <= read_value;
    end else if (shift_read) begin
      drive_low <= !shift_out[7];
      shift_out <= {shift_out[6:0], 1'b0};
    end else if (sck_fall && bit_count == `WORD_BITS) begin
      drive_low <= 1'b0;
    end
  end

  // Mode registers, the self-clearing reset bit and the sleep pulse of a soft reset.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      reset_bit <= 1'b0;
      reset_sleep_count <= 4'h0;
      format_powerdown_o <= `REG_RESET_VALUE;
      output_mode_o <= `REG_RESET_VALUE;
      pattern_high_o <= `REG_RESET_VALUE;
      pattern_low_o <= `REG_RESET_VALUE;
    end else begin
      if (!active) begin
        // The reset bit lives only until the write that set it has ended.
        reset_bit <= 1'b0;
      end
      if (reset_sleep_count != 4'h0) begin
        reset_sleep_count <= reset_sleep_count - 4'h1;
      end
      if (write_strobe) begin
        case (word_addr)
          `ADDR_SOFT_RESET: begin
            // Only the top bit acts; it is never readable, so it reads back as zero.
            if (next_shift_in[`SOFT_RESET_BIT]) begin
              reset_bit <= 1'b1;
              format_powerdown_o <= `REG_RESET_VALUE;
              output_mode_o <= `REG_RESET_VALUE;
              pattern_high_o <= `REG_RESET_VALUE;
              pattern_low_o <= `REG_RESET_VALUE;
              reset_sleep_count <= `SLEEP_PULSE_CYCLES;
            end
          end
          `ADDR_FORMAT_POWERDOWN: format_powerdown_o <= next_shift_in[7:0];
          `ADDR_OUTPUT_MODE: output_mode_o <= next_shift_in[7:0];
          `ADDR_PATTERN_HIGH: pattern_high_o <= next_shift_in[7:0];
          `ADDR_PATTERN_LOW: pattern_low_o <= next_shift_in[7:0];
          default: reset_bit <= reset_bit;
        endcase
      end
    end
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      chip_sleep_o <= 1'b0;
      channel_nap_o <= 4'h0;
      two_lane_16bit_o <= 1'b1;
      one_lane_14bit_o <= 1'b0;
      low_drive_current_o <= 1'b0;
      termination_on_o <= 1'b0;
    end else if (par_mode) begin
      chip_sleep_o <= sdi;
      channel_nap_o <= 4'h0;
      two_lane_16bit_o <= !cs_n;
      one_lane_14bit_o <= cs_n;
      low_drive_current_o <= sck;
      termination_on_o <= sdo_in;
    end else begin
      chip_sleep_o <= sleep_all || (reset_sleep_count != 4'h0) || reset_bit;
      channel_nap_o <= next_channel_nap;
      two_lane_16bit_o <= (output_mode_o[2:0] == 3'b000);
      one_lane_14bit_o <= (output_mode_o[2:0] == 3'b101);
      low_drive_current_o <= (output_mode_o[7:5] == 3'b111);
      termination_on_o <= output_mode_o[4];
    end
  end
endmodule // mode_config_port

// *** rtl/mode_port_defs.vh ***
// Constants for the converter mode configuration port.
`ifndef MODE_PORT_DEFS_VH
`define MODE_PORT_DEFS_VH
`define ADDR_SOFT_RESET 7'h00
`define ADDR_FORMAT_POWERDOWN 7'h01
`define ADDR_OUTPUT_MODE 7'h02
`define ADDR_PATTERN_HIGH 7'h03
`define ADDR_PATTERN_LOW 7'h04
`define REG_COUNT 5
`define REG_RESET_VALUE 8'h00
`define SOFT_RESET_BIT 7
`define SLEEP_BIT 4
`define WORD_BITS 16
`define BIT_COUNT_W 5
`define SLEEP_PULSE_CYCLES 4'h8
`define NAP_RECOVERY_SAMPLE_CYCLES 100
`define SLEEP_RECOVERY_US 2000
`define NAP_SETTLE_US 50
`endif

// *** rtl/pin_sync.v ***
// Two-flip-flop synchroniser for a group of asynchronous pins.
`timescale 1ns/1ns
module pin_sync #(
  parameter WIDTH = 4
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule // pin_sync
